//--- logic/ppil_pkg.sv
// ppil_pkg: constants for the pair emphasis, idle and loopback bank.
// assumes a Clause 22 management frame decoded on the 20 MHz system clock.
//
// How it works
// - pair registers bits 15:12 read zero, ignore writes
// - pair emphasis bits 11:10, resets high
// - override bit makes pair use own level
// - 0x13 low bits hold second idle character
// - 0x14 low bits hold first alternate idle
// - 0x15 low bits hold second alternate idle
// - pair registers reset 0x0C50, 0x0DBC, 0x0C50
// - loopback bits 15:8 enable serial loopback
// - serial loopback returns transmit data to receive
// - serial loopback tristates outputs, ignores serial input
// - serial loopback enable ORed with loop pin
// - loopback bits 7:0 enable far-end loopback
// - global emphasis level applies without override
// - codec steering is global enable input OR pin
package ppil_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [4:0] OFF_PAIR_CD = 5'h13;
  localparam logic [4:0] OFF_PAIR_EF = 5'h14;
  localparam logic [4:0] OFF_PAIR_GH = 5'h15;
  localparam logic [4:0] OFF_LOOP = 5'h16;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int PAIR_W = 12;            // bits 11:0 stored, 15:12 zero
  localparam int EMPH_HI = 11;
  localparam int EMPH_LO = 10;
  localparam int OVR_BIT = 9;
  localparam int IDLE_HI = 8;
  localparam int SER_LB_LO = 8;
  localparam logic [11:0] RST_PAIR_CD = 12'hC50;
  localparam logic [11:0] RST_PAIR_EF = 12'hDBC;
  localparam logic [11:0] RST_PAIR_GH = 12'hC50;
  localparam logic [15:0] RST_LOOP = 16'h0000;

  // ************************************************************
  // management frame
  // ************************************************************
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [5:0] LAST_ADDR_BIT = 6'h09;
  localparam logic [5:0] LAST_DATA_BIT = 6'h0F;

  typedef enum logic [6:0] {
    ST_PRE = 7'h01,
    ST_START = 7'h02,
    ST_OP = 7'h04,
    ST_ADDR = 7'h08,
    ST_TA = 7'h10,
    ST_DATA = 7'h20,
    ST_SKIP = 7'h40
  } ppil_mdio_e;

endpackage

//--- logic/ppil_chan_path.sv
// ppil_chan_path: one channel's loopback steering and emphasis level.
// assumes parallel and deserialized data are on the system clock.
`timescale 1ns/1ps
module ppil_chan_path (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ser_loop,
  input wire logic i_far_loop,
  input wire logic [1:0] i_emph_level,
  input wire logic [9:0] i_tx_par,
  input wire logic [9:0] i_rx_deser,
  output logic [9:0] o_rx_par,
  output logic [9:0] o_ser_tx,
  output logic o_ser_tx_oe,
  output logic [1:0] o_emph_level
);

  // ************************************************************
  // path selection
  // ************************************************************
  // serial loopback owns the parallel side when both are set
  wire logic [9:0] rx_sel = i_ser_loop ? i_tx_par : i_rx_deser;
  // far end sends received data back out the serializer
  wire logic [9:0] tx_sel = i_far_loop ? i_rx_deser : i_tx_par;

  // registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rx_par <= 10'h000;
      o_ser_tx <= 10'h000;
      o_ser_tx_oe <= 1'b0;
      o_emph_level <= 2'h3;
    end else begin
      o_rx_par <= rx_sel;
      o_ser_tx <= tx_sel;
      o_ser_tx_oe <= ~i_ser_loop;
      o_emph_level <= i_emph_level;
    end
  end

endmodule // ppil_chan_path

//--- logic/ppil_regs.sv
// ppil_regs: management registers 0x13..0x16 with the channel paths.
// assumes mdc, mdio, loop and codec pins are asynchronous pins; the
// global enable, global level and pair A/B fields come from logic.
`timescale 1ns/1ps
module ppil_regs (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_mdc,
  input wire logic i_mdio,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_loop_pin,
  input wire logic i_encoder_pin,
  input wire logic i_global_encoder_enable,
  input wire logic [1:0] i_global_emphasis_level,
  input wire logic [1:0] i_pair_ab_emphasis_level,
  input wire logic i_pair_ab_emphasis_override,
  input wire logic [79:0] i_tx_par,
  input wire logic [79:0] i_rx_deser,
  output logic o_mdio,
  output logic o_mdio_oe,
  output logic [79:0] o_rx_par,
  output logic [79:0] o_ser_tx,
  output logic [7:0] o_ser_tx_oe,
  output logic [15:0] o_emphasis_level,
  output logic o_codec_path_en,
  output logic [8:0] o_second_idle_char,
  output logic [8:0] o_first_alt_idle_char,
  output logic [8:0] o_second_alt_idle_char
);

  // ************************************************************
  // helpers
  // ************************************************************
  // pick the pair level or the global level
  function automatic logic [1:0] emph_sel(input logic ovr,
                                          input logic [1:0] pair_lvl,
                                          input logic [1:0] glob_lvl);
    emph_sel = ovr ? pair_lvl : glob_lvl;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] mdc_s_r;
  logic [1:0] mdio_s_r;
  logic [1:0] loop_s_r;
  logic [1:0] enc_s_r;
  logic [4:0] phy_s1_r;
  logic [4:0] phy_s2_r;
  logic mdc_d_r;

  // two stages per pin, then an edge history on mdc
  // mdc stages reset high: a pin idling high or low then shows no
  // false rising edge as reset lets go
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      mdc_s_r <= 2'h3;
      mdio_s_r <= 2'h3;
      loop_s_r <= 2'h0;
      enc_s_r <= 2'h0;
      phy_s1_r <= 5'h00;
      phy_s2_r <= 5'h00;
      mdc_d_r <= 1'b1;
    end else begin
      mdc_s_r <= {mdc_s_r[0], i_mdc};
      mdio_s_r <= {mdio_s_r[0], i_mdio};
      loop_s_r <= {loop_s_r[0], i_loop_pin};
      enc_s_r <= {enc_s_r[0], i_encoder_pin};
      phy_s1_r <= i_phy_addr;
      phy_s2_r <= phy_s1_r;
      mdc_d_r <= mdc_s_r[1];
    end
  end

  wire logic mdc_rise = mdc_s_r[1] & ~mdc_d_r;
  wire logic bit_in = mdio_s_r[1];

  // ************************************************************
  // register storage
  // ************************************************************
  logic [11:0] pair_cd_preemph_idle_two_r;
  logic [11:0] pair_ef_preemph_alt_idle_one_r;
  logic [11:0] pair_gh_preemph_alt_idle_two_r;
  logic [15:0] loopback_control_r;

  logic wr_en;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;

  // only bits 11:0 of the pair words are stored
  // a write lands in the cycle after the rise that samples bit 0;
  // other device addresses and unmapped offsets store nothing
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pair_cd_preemph_idle_two_r <= ppil_pkg::RST_PAIR_CD;
      pair_ef_preemph_alt_idle_one_r <= ppil_pkg::RST_PAIR_EF;
      pair_gh_preemph_alt_idle_two_r <= ppil_pkg::RST_PAIR_GH;
      loopback_control_r <= ppil_pkg::RST_LOOP;
    end else if (wr_en) begin
      if (wr_addr == ppil_pkg::OFF_PAIR_CD)
        pair_cd_preemph_idle_two_r <= wr_data[11:0];
      if (wr_addr == ppil_pkg::OFF_PAIR_EF)
        pair_ef_preemph_alt_idle_one_r <= wr_data[11:0];
      if (wr_addr == ppil_pkg::OFF_PAIR_GH)
        pair_gh_preemph_alt_idle_two_r <= wr_data[11:0];
      if (wr_addr == ppil_pkg::OFF_LOOP)
        loopback_control_r <= wr_data;
    end
  end

  // read mux, upper pair bits forced to zero
  // unmapped offsets are never driven, so the wire shows its pull-up
  wire logic [4:0] rd_addr;
  wire logic rd_mapped = (rd_addr >= ppil_pkg::OFF_PAIR_CD) &&
                         (rd_addr <= ppil_pkg::OFF_LOOP);
  wire logic [15:0] rd_word =
    (rd_addr == ppil_pkg::OFF_PAIR_CD) ?
      {4'h0, pair_cd_preemph_idle_two_r} :
    (rd_addr == ppil_pkg::OFF_PAIR_EF) ?
      {4'h0, pair_ef_preemph_alt_idle_one_r} :
    (rd_addr == ppil_pkg::OFF_PAIR_GH) ?
      {4'h0, pair_gh_preemph_alt_idle_two_r} :
    (rd_addr == ppil_pkg::OFF_LOOP) ? loopback_control_r : 16'h0000;

  // ************************************************************
  // management frame engine
  // ************************************************************
  ppil_pkg::ppil_mdio_e state_r;
  logic [5:0] cnt_r;
  logic [1:0] op_r;
  logic [9:0] addr_r;
  logic [15:0] sh_r;
  logic mdio_r;
  logic mdio_oe_r;

  wire logic [9:0] addr_next = {addr_r[8:0], bit_in};
  wire logic phy_hit = (addr_r[9:5] == phy_s2_r);
  wire logic is_read = (op_r == ppil_pkg::OP_READ);
  wire logic data_last = (cnt_r == ppil_pkg::LAST_DATA_BIT);
  assign rd_addr = addr_r[4:0];
  assign wr_en = mdc_rise && (state_r == ppil_pkg::ST_DATA) && data_last &&
                 !is_read && phy_hit;
  assign wr_addr = addr_r[4:0];
  assign wr_data = {sh_r[14:0], bit_in};

  // one step per rising mdc edge
  // preamble counts ones up to 32; a zero after them starts the frame
  // a bad start or opcode falls back to hunting for a new preamble
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= ppil_pkg::ST_PRE;
      cnt_r <= 6'h00;
      op_r <= 2'h0;
      addr_r <= 10'h000;
      sh_r <= 16'h0000;
      mdio_r <= 1'b1;
      mdio_oe_r <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        ppil_pkg::ST_PRE: begin
          if (bit_in) begin
            if (cnt_r != ppil_pkg::PREAMBLE_LEN)
              cnt_r <= cnt_r + 6'h01;
          end else begin
            if (cnt_r == ppil_pkg::PREAMBLE_LEN)
              state_r <= ppil_pkg::ST_START;
            cnt_r <= 6'h00;
          end
        end
        ppil_pkg::ST_START: begin
          state_r <= bit_in ? ppil_pkg::ST_OP : ppil_pkg::ST_PRE;
          cnt_r <= 6'h00;
        end
        ppil_pkg::ST_OP: begin
          op_r <= {op_r[0], bit_in};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r[0]) begin
            cnt_r <= 6'h00;
            if (({op_r[0], bit_in} == ppil_pkg::OP_READ) ||
                ({op_r[0], bit_in} == ppil_pkg::OP_WRITE))
              state_r <= ppil_pkg::ST_ADDR;
            else
              state_r <= ppil_pkg::ST_PRE;
          end
        end
        ppil_pkg::ST_ADDR: begin
          addr_r <= addr_next;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == ppil_pkg::LAST_ADDR_BIT) begin
            cnt_r <= 6'h00;
            state_r <= ppil_pkg::ST_TA;
          end
        end
        ppil_pkg::ST_TA: begin
          cnt_r <= cnt_r + 6'h01;
          if (!cnt_r[0]) begin
            // the first turnaround bit stays with the station
            // drive zero in the second turnaround bit
            if (is_read && phy_hit && rd_mapped) begin
              mdio_oe_r <= 1'b1;
              mdio_r <= 1'b0;
            end
            sh_r <= rd_word;
          end else begin
            cnt_r <= 6'h00;
            state_r <= ppil_pkg::ST_DATA;
            mdio_r <= sh_r[15];
            sh_r <= {sh_r[14:0], 1'b0};
          end
        end
        ppil_pkg::ST_DATA: begin
          cnt_r <= cnt_r + 6'h01;
          if (is_read) begin
            mdio_r <= sh_r[15];
            sh_r <= {sh_r[14:0], 1'b0};
          end else begin
            sh_r <= wr_data;
          end
          if (data_last) begin
            cnt_r <= 6'h00;
            mdio_oe_r <= 1'b0;
            mdio_r <= 1'b1;
            state_r <= ppil_pkg::ST_PRE;
          end
        end
        default: begin
          cnt_r <= 6'h00;
          mdio_oe_r <= 1'b0;
          state_r <= ppil_pkg::ST_PRE;
        end
      endcase
    end
  end

  assign o_mdio = mdio_r;
  assign o_mdio_oe = mdio_oe_r;

  // ************************************************************
  // effective enables and levels
  // ************************************************************
  // register bit or the loop pin, per channel
  // pins pass two stages, so they act two cycles after a register bit
  wire logic [7:0] ser_loop_eff =
    loopback_control_r[15:8] | {8{loop_s_r[1]}};
  // far-end bits taken as written; pairing is up to software
  wire logic [7:0] far_loop_eff = loopback_control_r[7:0];
  wire logic codec_eff = i_global_encoder_enable | enc_s_r[1];

  wire logic [1:0] lvl_ab = emph_sel(i_pair_ab_emphasis_override,
    i_pair_ab_emphasis_level, i_global_emphasis_level);
  wire logic [1:0] lvl_cd = emph_sel(
    pair_cd_preemph_idle_two_r[ppil_pkg::OVR_BIT],
    pair_cd_preemph_idle_two_r[ppil_pkg::EMPH_HI:ppil_pkg::EMPH_LO],
    i_global_emphasis_level);
  wire logic [1:0] lvl_ef = emph_sel(
    pair_ef_preemph_alt_idle_one_r[ppil_pkg::OVR_BIT],
    pair_ef_preemph_alt_idle_one_r[ppil_pkg::EMPH_HI:ppil_pkg::EMPH_LO],
    i_global_emphasis_level);
  wire logic [1:0] lvl_gh = emph_sel(
    pair_gh_preemph_alt_idle_two_r[ppil_pkg::OVR_BIT],
    pair_gh_preemph_alt_idle_two_r[ppil_pkg::EMPH_HI:ppil_pkg::EMPH_LO],
    i_global_emphasis_level);
  wire logic [7:0] lvl_pairs = {lvl_gh, lvl_ef, lvl_cd, lvl_ab};

  // codec steering flag follows the effective enable
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn)
      o_codec_path_en <= 1'b0;
    else
      o_codec_path_en <= codec_eff;
  end

  // idle fields straight from the stored words
  // these are flop bits, so the outputs need no extra stage
  assign o_second_idle_char =
    pair_cd_preemph_idle_two_r[ppil_pkg::IDLE_HI:0];
  assign o_first_alt_idle_char =
    pair_ef_preemph_alt_idle_one_r[ppil_pkg::IDLE_HI:0];
  assign o_second_alt_idle_char =
    pair_gh_preemph_alt_idle_two_r[ppil_pkg::IDLE_HI:0];

  // ************************************************************
  // channel paths, A at index 0 up to H at 7
  // ************************************************************
  // both channels of a pair read the same two-bit level slice
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      ppil_chan_path u_path (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_ser_loop(ser_loop_eff[ch]),
        .i_far_loop(far_loop_eff[ch]),
        .i_emph_level(lvl_pairs[2*(ch/2) +: 2]),
        .i_tx_par(i_tx_par[10*ch +: 10]),
        .i_rx_deser(i_rx_deser[10*ch +: 10]),
        .o_rx_par(o_rx_par[10*ch +: 10]),
        .o_ser_tx(o_ser_tx[10*ch +: 10]),
        .o_ser_tx_oe(o_ser_tx_oe[ch]),
        .o_emph_level(o_emphasis_level[2*ch +: 2])
      );
    end
  endgenerate

endmodule // ppil_regs

//--- verification/ppil_regs_asserts.sv
// ppil_regs_asserts: timing checks on loopback, codec and level ports.
// assumes one 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ppil_regs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_loop_pin,
  input wire logic i_encoder_pin,
  input wire logic i_global_encoder_enable,
  input wire logic [1:0] i_global_emphasis_level,
  input wire logic [1:0] i_pair_ab_emphasis_level,
  input wire logic i_pair_ab_emphasis_override,
  input wire logic [79:0] i_tx_par,
  input wire logic [79:0] i_rx_deser,
  input wire logic o_mdio_oe,
  input wire logic [79:0] o_rx_par,
  input wire logic [7:0] o_ser_tx_oe,
  input wire logic [15:0] o_emphasis_level,
  input wire logic o_codec_path_en,
  input wire logic [8:0] o_second_idle_char,
  input wire logic [8:0] o_first_alt_idle_char,
  input wire logic [8:0] o_second_alt_idle_char
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // ************************************************************
  // named steps
  // ************************************************************
  sequence pin_held;
    i_loop_pin [*4];
  endsequence
  sequence codec_quiet;
    (!i_global_encoder_enable && !i_encoder_pin) [*4];
  endsequence

  // parallel receive source follows the serial tx enable
  for (genvar c = 0; c < 8; c++) begin : g_ch
    ser_return_a: assert property (
      $past(i_resetn) && !o_ser_tx_oe[c]
      |-> o_rx_par[10*c+:10] == $past(i_tx_par[10*c+:10]))
      else $error("loopback rx differs from tx");
    rx_normal_a: assert property (
      o_ser_tx_oe[c] |-> o_rx_par[10*c+:10] == $past(i_rx_deser[10*c+:10]))
      else $error("rx differs from deserializer");
  end

  // pin, codec and pair a/b level relations
  pin_loop_a: assert property (pin_held |=> o_ser_tx_oe == 8'h00)
    else $error("loop pin did not tristate");
  codec_on_a: assert property (
    i_global_encoder_enable [*2] |=> o_codec_path_en)
    else $error("codec path off with enable");
  codec_off_a: assert property (codec_quiet |=> !o_codec_path_en)
    else $error("codec path on without cause");
  // sampled reset in the antecedent: the release edge still resets levels
  ab_global_a: assert property (
    i_resetn && !i_pair_ab_emphasis_override |=>
    o_emphasis_level[3:0] == {2{$past(i_global_emphasis_level)}})
    else $error("pair ab level not global");
  ab_own_a: assert property (
    i_resetn && i_pair_ab_emphasis_override |=>
    o_emphasis_level[3:0] == {2{$past(i_pair_ab_emphasis_level)}})
    else $error("pair ab level not own");
  reset_idle_a: assert property ($rose(i_resetn) |->
    o_second_idle_char == 9'h050 && o_first_alt_idle_char == 9'h1BC &&
    o_second_alt_idle_char == 9'h050 && !o_mdio_oe)
    else $error("idle fields wrong after reset");
endmodule // ppil_regs_asserts

bind ppil_regs ppil_regs_asserts u_chk (.i_sys_clk, .i_resetn,
  .i_loop_pin, .i_encoder_pin, .i_global_encoder_enable,
  .i_global_emphasis_level, .i_pair_ab_emphasis_level,
  .i_pair_ab_emphasis_override, .i_tx_par, .i_rx_deser, .o_mdio_oe,
  .o_rx_par, .o_ser_tx_oe, .o_emphasis_level, .o_codec_path_en,
  .o_second_idle_char, .o_first_alt_idle_char, .o_second_alt_idle_char);

//--- verification/ppil_sta.sv
// ppil_sta: management station model making clause 22 frames.
// assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module ppil_sta (
  input wire logic i_sys_clk,
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  logic q;
  initial begin
    o_mdc = 1'b1;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_data = 16'h0000;
  end
  // one bit: 6 clocks low then 6 high, wire sampled before the rise
  task automatic bit_t(input logic d, input logic en);
    o_mdio <= d;
    o_mdio_oe <= en;
    o_mdc <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    q = i_mdio;
    o_mdc <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
  endtask
  // whole frame; a read reports its word as a one-cycle pulse
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd);
    logic [45:0] hd;
    logic [15:0] rd;
    logic w;
    w = (op == ppil_pkg::OP_WRITE);
    hd = {32'hFFFFFFFF, 2'h1, op, phy, ra};
    for (int i = 45; i >= 0; i--) bit_t(hd[i], 1'b1);
    bit_t(1'b1, w);
    bit_t(1'b0, w);
    for (int i = 15; i >= 0; i--) begin
      bit_t(wd[i], w);
      rd[i] = q;
    end
    o_mdio_oe <= 1'b0;
    o_rd_data <= rd;
    o_rd_valid <= !w;
    @(posedge i_sys_clk);
    o_rd_valid <= 1'b0;
  endtask
endmodule // ppil_sta

//--- verification/test_pair_preemph_idle_loopback_regs.sv
// test bench: register, emphasis and loopback checks through frames.
// assumes ppil_regs, ppil_sta and the bound checker are compiled.
`timescale 1ns/1ps
module test_pair_preemph_idle_loopback_regs;
  localparam logic [4:0] PHY = 5'h05;
  logic clk, rstn, lpin, epin, gen, abo, sv, rv, mo, moe, so, soe, w, mc;
  logic [1:0] gl, abl, sel;
  logic [79:0] tx, rx, orx, ost, obs, got, ex, rxe, ste, tn;
  logic [7:0] oe, oee;
  logic [15:0] emp, rdd, r, sh [0:3];
  logic [8:0] i1, i2, i3;
  logic cod;
  logic [79:0] expq[$];
  int fails, n_tests;
  // wire with pull-up, then the observed group
  assign w = moe ? mo : (soe ? so : 1'b1);
  assign obs = sel == 2'h0 ? orx : sel == 2'h1 ? ost :
    {28'h0, oe, cod, emp, i1, i2, i3};
  ppil_regs u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_mdc(mc),
    .i_mdio(w), .i_phy_addr(PHY), .i_loop_pin(lpin), .i_encoder_pin(epin),
    .i_global_encoder_enable(gen), .i_global_emphasis_level(gl),
    .i_pair_ab_emphasis_level(abl), .i_pair_ab_emphasis_override(abo),
    .i_tx_par(tx), .i_rx_deser(rx), .o_mdio(mo), .o_mdio_oe(moe),
    .o_rx_par(orx), .o_ser_tx(ost), .o_ser_tx_oe(oe),
    .o_emphasis_level(emp), .o_codec_path_en(cod),
    .o_second_idle_char(i1), .o_first_alt_idle_char(i2),
    .o_second_alt_idle_char(i3));
  ppil_sta u_sta (.i_sys_clk(clk), .i_mdio(w), .o_mdc(mc), .o_mdio(so),
    .o_mdio_oe(soe), .o_rd_valid(rv), .o_rd_data(rdd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // monitor: oldest note against each result
  always @(negedge clk) begin
    if (rv || sv) begin
      got = rv ? {64'h0, rdd} : obs;
      ex = expq.size() > 0 ? expq.pop_front() : 'x;
      n_tests++;
      if (got !== ex) begin
        $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
        fails++;
      end
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input int i, input logic [4:0] p, input logic [15:0] d);
    if (p == PHY && i < 4) sh[i] = i < 3 ? d & 16'h0FFF : d;
    u_sta.frame(ppil_pkg::OP_WRITE, p, ppil_pkg::OFF_PAIR_CD + 5'(i), d);
  endtask
  task automatic rd(input int i, input logic [15:0] e);
    expq.push_back({64'h0, e});
    u_sta.frame(ppil_pkg::OP_READ, PHY, ppil_pkg::OFF_PAIR_CD + 5'(i),
      16'h0000);
  endtask
  task automatic chk(input logic [1:0] s, input logic [79:0] e);
    expq.push_back(e);
    sel <= s;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
  endtask
  // expected ports from the shadow registers and pins
  task automatic all_out();
    logic [15:0] e;
    repeat (4) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      if (c < 2) e[2*c+:2] = abo ? abl : gl;
      else e[2*c+:2] = sh[c/2-1][9] ? sh[c/2-1][11:10] : gl;
      oee[c] = !(sh[3][8+c] | lpin);
      rxe[10*c+:10] = oee[c] ? rx[10*c+:10] : tx[10*c+:10];
      ste[10*c+:10] = sh[3][c] ? rx[10*c+:10] : tx[10*c+:10];
    end
    chk(2'h0, rxe);
    chk(2'h1, ste);
    chk(2'h2, {28'h0, oee, gen | epin, e, sh[0][8:0], sh[1][8:0],
      sh[2][8:0]});
  endtask
  initial begin
    {rstn, lpin, epin, gen, abo, sv, gl, abl, sel} = '0;
    {tx, rx} = '0;
    r = 16'h0025;
    sh = '{16'h0C50, 16'h0DBC, 16'h0C50, 16'h0000};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) rd(i, sh[i]);
    all_out();
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      wr(i, PHY, 16'hFFFF);
      rd(i, 16'h0FFF);
      r = nx(r);
      wr(i, PHY, r);
      rd(i, sh[i]);
    end
    $display("field access done");
    for (int l = 0; l < 4; l++) begin
      gl <= 2'(l);
      abl <= ~2'(l);
      abo <= l[0];
      gen <= l[0];
      epin <= l[1];
      wr(0, PHY, {4'hA, 2'(l), 1'b1, 9'h1AA});
      wr(1, PHY, {4'h0, 2'(l) ^ 2'h1, l[1], 9'h0F3});
      all_out();
    end
    $display("emphasis done");
    for (int k = 0; k < 4; k++) begin
      // five fresh words fill all 80 bits, driven once per step
      repeat (5) begin
        r = nx(r);
        tn = {tn[63:0], r};
      end
      tx <= tn;
      rx <= ~tn;
      r = nx(r);
      lpin <= (k == 3);
      wr(3, PHY, {k == 0 ? 8'hFF : r[7:0], {2{r[11]}}, {2{r[10]}},
        {2{r[9]}}, {2{r[8]}}});
      rd(3, sh[3]);
      all_out();
    end
    $display("loopback done");
    wr(0, 5'h1A, 16'h0000);
    rd(0, sh[0]);
    wr(4, PHY, 16'h0000);
    rd(4, 16'hFFFF);
    all_out();
    $display("refusals done");
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule // test_pair_preemph_idle_loopback_regs
